/* File: hdl/acsd_pkg.sv */
// constants shared by both ends of the three-wire control bus
// ============================================================
package acsd_pkg;
    // ========================================================
    // selector codes
    localparam logic [7:0] ACSD_SEL_SOURCE = 8'h40;
    localparam logic [7:0] ACSD_SEL_LOUD = 8'h41;
    localparam logic [7:0] ACSD_SEL_LOW_TONE = 8'h42;
    localparam logic [7:0] ACSD_SEL_HIGH_TONE = 8'h43;
    localparam logic [7:0] ACSD_SEL_LEFT = 8'h44;
    localparam logic [7:0] ACSD_SEL_RIGHT = 8'h45;
    localparam logic [7:0] ACSD_SEL_MODE = 8'h46;
    localparam logic [7:0] ACSD_SEL_FLAGS = 8'h47;
    localparam logic [4:0] ACSD_SEL_BASE = 5'h08;
    // ========================================================
    // field codes and reset values
    localparam logic [1:0] ACSD_SRC_ONE = 2'h0;
    localparam logic [1:0] ACSD_SRC_TWO = 2'h1;
    localparam logic [1:0] ACSD_SRC_NONE = 2'h2;
    localparam logic [1:0] ACSD_SRC_MUTE = 2'h3;
    localparam logic [3:0] ACSD_TONE_FLAT = 4'h6;
    localparam logic [5:0] ACSD_VOL_MIN = 6'h3F;
    localparam logic [5:0] ACSD_VOL_FLOOR = 6'h28;
    localparam logic [6:0] ACSD_VOL_FLOOR_DB = 7'h50;
    localparam logic [6:0] ACSD_VOL_STEP_DB = 7'h02;
    localparam logic [7:0] ACSD_TONE_MIN_DB = 8'hF4;
    localparam logic [7:0] ACSD_TONE_MAX_DB = 8'h0C;
    localparam logic [7:0] ACSD_TONE_STEP_DB = 8'h02;
    localparam logic [1:0] ACSD_MODE_LEFT = 2'h0;
    localparam logic [1:0] ACSD_MODE_STEREO = 2'h1;
    localparam logic [1:0] ACSD_MODE_RIGHT = 2'h2;
    localparam logic [4:0] ACSD_BITS_FRAME = 5'h10;
    localparam logic [4:0] ACSD_BITS_SEL = 5'h08;
    // ========================================================
    // controller command port and timing
    localparam logic [3:0] ACSD_REG_CMD = 4'h0;
    localparam logic [3:0] ACSD_REG_STATUS = 4'h1;
    localparam logic [3:0] ACSD_REG_RXVAL = 4'h2;
    localparam int ACSD_CLK_NS = 100;
    localparam int ACSD_BIT_NS = 1000;
    localparam int ACSD_BIT_CYC = (ACSD_BIT_NS + ACSD_CLK_NS - 1) / ACSD_CLK_NS;
    localparam logic [3:0] ACSD_HALF_CYC = 4'((ACSD_BIT_CYC + 1) / 2);
endpackage : acsd_pkg

/* File: hdl/acsd_bus_if.sv */
// three-wire control bus joining controller and decoder
`timescale 1ns/100ps
interface acsd_bus_if;
    logic bus_clk; // bus clock from controller
    logic select_strobe; // low during selector byte
    logic ctl_data_out; // controller data output level
    logic ctl_data_oe; // controller pulls line
    logic dev_data_out; // decoder data output level
    logic dev_data_oe; // decoder pulls line
    logic data_line; // resolved wired line

    // open drain with pull-up: any enabled low output wins
    assign data_line = ~((ctl_data_oe & ~ctl_data_out)
                       | (dev_data_oe & ~dev_data_out));

    modport ctl (output bus_clk, output select_strobe,
                 output ctl_data_out, output ctl_data_oe,
                 input data_line);
    modport dev (input bus_clk, input select_strobe,
                 output dev_data_out, output dev_data_oe,
                 input data_line);
endinterface : acsd_bus_if

/* File: hdl/acsd_decoder.sv */
// audio control word decoder, the device end of the bus
`timescale 1ns/100ps
module acsd_decoder
    import acsd_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic arst_n, // async reset, active low
    acsd_bus_if.dev bus, // three-wire control bus
    input wire logic flag_one_n, // external flag one, active low
    input wire logic flag_two_n, // external flag two, active low
    output logic [1:0] source_sel, // selected source code
    output logic mute_on, // muting active
    output logic loudness_on, // loudness contour on
    output logic widening_on, // enhanced stereo on
    output logic [3:0] low_tone_code, // bass code
    output logic [3:0] high_tone_code, // treble code
    output logic [7:0] low_tone_db, // bass gain, signed dB
    output logic [7:0] high_tone_db, // treble gain, signed dB
    output logic [5:0] left_atten_code, // left volume code
    output logic [5:0] right_atten_code, // right volume code
    output logic [6:0] left_atten_db, // left attenuation, dB
    output logic [6:0] right_atten_db, // right attenuation, dB
    output logic [1:0] matrix_mode, // output matrix mode
    output logic cmd_applied // pulse at the end of every frame for this decoder, flag reads included
);
    // ========================================================
    // decoding helpers
    // tone code to signed dB; 11XX saturates at full boost
    function automatic logic [7:0] tone_db(input logic [3:0] c);
        logic [7:0] r;
        r = ACSD_TONE_MIN_DB + ACSD_TONE_STEP_DB * {4'h0, c};
        if (c[3:2] == 2'h3)
        begin
            r = ACSD_TONE_MAX_DB;
        end
        return r;
    endfunction : tone_db

    // volume code to attenuation; floor codes all mean -80 dB
    function automatic logic [6:0] atten_db(input logic [5:0] c);
        logic [6:0] r;
        r = ACSD_VOL_STEP_DB * {1'b0, c};
        if (c >= ACSD_VOL_FLOOR)
        begin
            r = ACSD_VOL_FLOOR_DB;
        end
        return r;
    endfunction : atten_db

    // ========================================================
    // pin synchronisers: clock, strobe, data line, flags
    logic [1:0] clk_sync_q;
    logic [1:0] stb_sync_q;
    logic [1:0] dat_sync_q;
    logic [1:0] fl1_sync_q;
    logic [1:0] fl2_sync_q;
    logic clk_prev_q;
    logic stb_prev_q;

    // two stages each; only stage one feeds stage two
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clk_sync_q <= 2'h3;
            stb_sync_q <= 2'h3;
            dat_sync_q <= 2'h3;
            fl1_sync_q <= 2'h3;
            fl2_sync_q <= 2'h3;
            clk_prev_q <= 1'b1;
            stb_prev_q <= 1'b1;
        end
        else
        begin
            clk_sync_q <= {clk_sync_q[0], bus.bus_clk};
            stb_sync_q <= {stb_sync_q[0], bus.select_strobe};
            dat_sync_q <= {dat_sync_q[0], bus.data_line};
            fl1_sync_q <= {fl1_sync_q[0], flag_one_n};
            fl2_sync_q <= {fl2_sync_q[0], flag_two_n};
            clk_prev_q <= clk_sync_q[1];
            stb_prev_q <= stb_sync_q[1];
        end
    end

    logic bus_rise;
    logic bus_fall;
    logic frame_start;
    // only the bus clock rising edge takes a bit
    assign bus_rise = clk_sync_q[1] & ~clk_prev_q;
    assign bus_fall = ~clk_sync_q[1] & clk_prev_q;
    assign frame_start = ~stb_sync_q[1] & stb_prev_q;

    // ========================================================
    // frame shifter and bit counter
    logic [4:0] bit_cnt_q;
    logic [7:0] sel_q;
    logic [7:0] val_q;
    logic sel_ok;
    logic last_bit;
    assign sel_ok = (sel_q[7:3] == ACSD_SEL_BASE);
    // sixteenth rising edge closes the command
    assign last_bit = bus_rise & stb_sync_q[1] & sel_ok
                    & (bit_cnt_q == ACSD_BITS_FRAME - 5'h01);

    // selector bits only while strobe low, value bits after it
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bit_cnt_q <= 5'h00;
            sel_q <= 8'h00;
            val_q <= 8'h00;
        end
        else if (frame_start)
        begin
            bit_cnt_q <= 5'h00;
            sel_q <= 8'h00;
        end
        else if (bus_rise)
        begin
            if (!stb_sync_q[1] && bit_cnt_q < ACSD_BITS_SEL)
            begin
                sel_q <= {sel_q[6:0], dat_sync_q[1]};
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            else if (stb_sync_q[1] && bit_cnt_q >= ACSD_BITS_SEL
                     && bit_cnt_q < ACSD_BITS_FRAME)
            begin
                val_q <= {val_q[6:0], dat_sync_q[1]};
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    logic [7:0] new_val;
    assign new_val = {val_q[6:0], dat_sync_q[1]};

    // ========================================================
    // holding registers, written when the value byte is in
    logic [1:0] source_q;
    logic loud_q;
    logic widen_q;
    logic [3:0] low_q;
    logic [3:0] high_q;
    logic [5:0] left_q;
    logic [5:0] right_q;
    logic [1:0] mode_q;
    logic applied_q;

    // unlisted codes and foreign selectors leave settings alone
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            source_q <= ACSD_SRC_MUTE;
            loud_q <= 1'b0;
            widen_q <= 1'b0;
            low_q <= ACSD_TONE_FLAT;
            high_q <= ACSD_TONE_FLAT;
            left_q <= ACSD_VOL_MIN;
            right_q <= ACSD_VOL_MIN;
            mode_q <= ACSD_MODE_STEREO;
            applied_q <= 1'b0;
        end
        else
        begin
            applied_q <= last_bit;
            if (last_bit)
            begin
                case (sel_q)
                    ACSD_SEL_SOURCE:
                    begin
                        if (new_val[1:0] != ACSD_SRC_NONE)
                        begin
                            source_q <= new_val[1:0];
                        end
                    end
                    ACSD_SEL_LOUD:
                    begin
                        loud_q <= new_val[0];
                        widen_q <= new_val[1];
                    end
                    ACSD_SEL_LOW_TONE: low_q <= new_val[3:0];
                    ACSD_SEL_HIGH_TONE: high_q <= new_val[3:0];
                    ACSD_SEL_LEFT: left_q <= new_val[5:0];
                    ACSD_SEL_RIGHT: right_q <= new_val[5:0];
                    ACSD_SEL_MODE:
                    begin
                        // 0XX codes are unassigned and ignored
                        if (new_val[2:1] == 2'h3)
                        begin
                            mode_q <= ACSD_MODE_RIGHT;
                        end
                        else if (new_val[2])
                        begin
                            mode_q <= new_val[0] ? ACSD_MODE_STEREO
                                                 : ACSD_MODE_LEFT;
                        end
                    end
                    default:
                    begin
                        mode_q <= mode_q;
                    end
                endcase
            end
        end
    end

    // ========================================================
    // flag readback on the data line
    logic [7:0] flag_word_q;
    logic drive_q;
    logic reading;
    logic [2:0] rd_idx;
    assign reading = (sel_q == ACSD_SEL_FLAGS) & stb_sync_q[1];
    assign rd_idx = 3'(ACSD_BITS_FRAME - 5'h01 - bit_cnt_q);

    // flags frozen at the selector's end so a byte stays coherent
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flag_word_q <= 8'hFF;
        end
        else if (bus_rise && !stb_sync_q[1]
                 && bit_cnt_q == ACSD_BITS_SEL - 5'h01)
        begin
            flag_word_q <= {6'h3F, fl2_sync_q[1], fl1_sync_q[1]};
        end
    end

    // bit changes after falling edge, holds through the rise
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            drive_q <= 1'b0;
        end
        else if (frame_start || last_bit)
        begin
            drive_q <= 1'b0;
        end
        else if (bus_fall)
        begin
            drive_q <= reading && bit_cnt_q >= ACSD_BITS_SEL
                       && bit_cnt_q < ACSD_BITS_FRAME
                       && !flag_word_q[rd_idx];
        end
    end

    // ========================================================
    // outputs
    assign bus.dev_data_out = 1'b0;
    assign bus.dev_data_oe = drive_q;
    assign source_sel = source_q;
    assign mute_on = (source_q == ACSD_SRC_MUTE);
    assign loudness_on = loud_q;
    assign widening_on = widen_q;
    assign low_tone_code = low_q;
    assign high_tone_code = high_q;
    assign low_tone_db = tone_db(low_q);
    assign high_tone_db = tone_db(high_q);
    assign left_atten_code = left_q;
    assign right_atten_code = right_q;
    assign left_atten_db = atten_db(left_q);
    assign right_atten_db = atten_db(right_q);
    assign matrix_mode = mode_q;
    assign cmd_applied = applied_q;
endmodule : acsd_decoder

/* File: hdl/acsd_controller.sv */
// bus controller: sends sixteen-bit commands, reads flags
`timescale 1ns/100ps
module acsd_controller
    import acsd_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic [3:0] reg_addr, // command port address
    input wire logic [15:0] reg_wdata, // command port write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [15:0] reg_rdata, // read data, cycle after strobe
    acsd_bus_if.ctl bus // three-wire control bus
);
    typedef enum logic [1:0] {
        ACSD_ST_IDLE = 2'b00,
        ACSD_ST_LOW = 2'b01,
        ACSD_ST_HIGH = 2'b10
    } acsd_state_e;

    // ========================================================
    // line synchroniser for readback
    logic [1:0] line_sync_q;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            line_sync_q <= 2'h3;
        end
        else
        begin
            line_sync_q <= {line_sync_q[0], bus.data_line};
        end
    end

    // ========================================================
    // frame sequencer
    acsd_state_e state_q;
    logic [3:0] half_q;
    logic [3:0] bit_q;
    logic [15:0] tx_q;
    logic [7:0] rx_q;
    logic clk_q;
    logic stb_q;
    logic oe_q;
    logic rd_frame_q;
    logic start;
    logic half_done;
    assign start = reg_wr && reg_addr == ACSD_REG_CMD
                   && state_q == ACSD_ST_IDLE;
    // half period of at least 500 ns keeps the rate at 1 MHz
    assign half_done = (half_q == ACSD_HALF_CYC - 4'h1);

    // bits change in the low phase and hold over the rising edge
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= ACSD_ST_IDLE;
            half_q <= 4'h0;
            bit_q <= 4'h0;
            tx_q <= 16'h0000;
            rx_q <= 8'h00;
            clk_q <= 1'b1;
            stb_q <= 1'b1;
            oe_q <= 1'b0;
            rd_frame_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ACSD_ST_IDLE:
                begin
                    if (start)
                    begin
                        tx_q <= reg_wdata;
                        // selector is shifted away, so remember a read
                        rd_frame_q <= reg_wdata[15:8] == ACSD_SEL_FLAGS;
                        bit_q <= 4'h0;
                        half_q <= 4'h0;
                        stb_q <= 1'b0;
                        clk_q <= 1'b0;
                        oe_q <= ~reg_wdata[15];
                        state_q <= ACSD_ST_LOW;
                    end
                end
                ACSD_ST_LOW:
                begin
                    half_q <= half_done ? 4'h0 : half_q + 4'h1;
                    if (half_done)
                    begin
                        clk_q <= 1'b1;
                        state_q <= ACSD_ST_HIGH;
                    end
                end
                ACSD_ST_HIGH:
                begin
                    half_q <= half_done ? 4'h0 : half_q + 4'h1;
                    if (half_done)
                    begin
                        rx_q <= {rx_q[6:0], line_sync_q[1]};
                        if (bit_q == 4'hF)
                        begin
                            oe_q <= 1'b0;
                            state_q <= ACSD_ST_IDLE;
                        end
                        else
                        begin
                            bit_q <= bit_q + 4'h1;
                            clk_q <= 1'b0;
                            tx_q <= {tx_q[14:0], 1'b1};
                            state_q <= ACSD_ST_LOW;
                            if (bit_q == 4'h7)
                            begin
                                stb_q <= 1'b1;
                            end
                            // line left free while flags come back
                            oe_q <= ~tx_q[14]
                                    && !(rd_frame_q && bit_q >= 4'h7);
                        end
                    end
                end
                default:
                begin
                    state_q <= ACSD_ST_IDLE;
                end
            endcase
        end
    end

    // ========================================================
    // command port read side
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata <= 16'h0000;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                ACSD_REG_STATUS:
                    reg_rdata <= {15'h0000, state_q != ACSD_ST_IDLE};
                ACSD_REG_RXVAL: reg_rdata <= {8'h00, rx_q};
                default: reg_rdata <= 16'h0000;
            endcase
        end
        else
        begin
            reg_rdata <= 16'h0000;
        end
    end

    assign bus.bus_clk = clk_q;
    assign bus.select_strobe = stb_q;
    assign bus.ctl_data_out = 1'b0;
    assign bus.ctl_data_oe = oe_q;
endmodule : acsd_controller

/* File: tb/acsd_bus_chk.sv */
// checker for the three-wire control bus between both ends
`timescale 1ns/100ps
module acsd_bus_chk
(
    input logic clk, // system clock
    input logic arst_n, // async reset, active low
    input logic bus_clk, // bus clock from controller
    input logic select_strobe, // low during selector byte
    input logic ctl_data_out, // controller output level
    input logic ctl_data_oe, // controller pulls line
    input logic dev_data_out, // decoder output level
    input logic dev_data_oe, // decoder pulls line
    input logic data_line // resolved wire
);
    // ========================================================
    // helper: bus clock rises seen while the strobe is low
    logic [4:0] sel_rises_q;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sel_rises_q <= 5'h00;
        else if ($fell(select_strobe))
            sel_rises_q <= 5'h00;
        else if (!select_strobe && $rose(bus_clk))
            sel_rises_q <= sel_rises_q + 5'h01;
    end

    // ========================================================
    // properties, all in the system clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_ctl_open_drain: assert property (ctl_data_out == 1'b0)
        else $error("controller drives the line high");
    a_dev_open_drain: assert property (dev_data_out == 1'b0)
        else $error("decoder drives the line high");
    a_line_pulled_up: assert property (
        data_line == !(ctl_data_oe || dev_data_oe))
        else $error("data line level wrong");
    // a full bit takes ten cycles, which is the 1 MHz ceiling
    a_low_phase_len: assert property (
        $fell(bus_clk) |-> !bus_clk[*5] ##1 bus_clk)
        else $error("bus clock low phase not five cycles");
    a_high_phase_len: assert property ($rose(bus_clk) |-> bus_clk[*5])
        else $error("bus clock high phase too short");
    a_sel_eight_bits: assert property (
        $rose(select_strobe) |-> sel_rises_q == 5'h08)
        else $error("selector byte not eight bits");
    a_ctl_stable_edge: assert property (
        $rose(bus_clk) |-> $stable(ctl_data_oe))
        else $error("controller data moved at rising edge");
    a_dev_rise_low: assert property ($rose(dev_data_oe) |-> !bus_clk)
        else $error("decoder drove line while clock high");
    a_dev_release: assert property (
        $fell(select_strobe) |-> ##4 !dev_data_oe[*8])
        else $error("decoder still pulls line in new frame");
endmodule : acsd_bus_chk

/* File: tb/test_audio_control_serial_decoder.sv */
// self-checking bench: controller and decoder joined by the bus
`timescale 1ns/100ps
module test_audio_control_serial_decoder;
    import acsd_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic flag_one_n = 1'b1;
    logic flag_two_n = 1'b1;
    logic [1:0] source_sel, matrix_mode;
    logic mute_on, loudness_on, widening_on, cmd_applied;
    logic [3:0] low_tone_code, high_tone_code;
    logic [7:0] low_tone_db, high_tone_db;
    logic [5:0] left_atten_code, right_atten_code;
    logic [6:0] left_atten_db, right_atten_db;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int n_applied = 0;
    // expected settings, reset values first
    logic [1:0] e_src = 2'h3;
    logic [1:0] e_mode = 2'h1;
    logic e_loud = 1'b0;
    logic e_wide = 1'b0;
    logic [3:0] e_low = 4'h6;
    logic [3:0] e_high = 4'h6;
    logic [5:0] e_left = 6'h3F;
    logic [5:0] e_right = 6'h3F;
    logic [15:0] d;
    logic [15:0] corners [10] = '{16'h4400, 16'h4514, 16'h4428, 16'h42FF,
        16'h43F0, 16'h46FC, 16'h4002, 16'h4103, 16'h4806, 16'h3F00};

    always #50 clk = ~clk;

    acsd_bus_if bus ();
    acsd_controller u_acsd_controller (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus(bus));
    acsd_decoder u_acsd_decoder (.clk(clk), .arst_n(arst_n), .bus(bus),
        .flag_one_n(flag_one_n), .flag_two_n(flag_two_n),
        .source_sel(source_sel), .mute_on(mute_on),
        .loudness_on(loudness_on), .widening_on(widening_on),
        .low_tone_code(low_tone_code), .high_tone_code(high_tone_code),
        .low_tone_db(low_tone_db), .high_tone_db(high_tone_db),
        .left_atten_code(left_atten_code),
        .right_atten_code(right_atten_code),
        .left_atten_db(left_atten_db), .right_atten_db(right_atten_db),
        .matrix_mode(matrix_mode), .cmd_applied(cmd_applied));
    acsd_bus_chk u_acsd_bus_chk (.clk(clk), .arst_n(arst_n),
        .bus_clk(bus.bus_clk), .select_strobe(bus.select_strobe),
        .ctl_data_out(bus.ctl_data_out), .ctl_data_oe(bus.ctl_data_oe),
        .dev_data_out(bus.dev_data_out), .dev_data_oe(bus.dev_data_oe),
        .data_line(bus.data_line));

    // ========================================================
    // expectation helpers
    function automatic logic [7:0] tdb(input logic [3:0] c);
        return (c >= 4'hC) ? 8'h0C : 8'hF4 + {3'h0, c, 1'b0};
    endfunction : tdb
    function automatic logic [6:0] adb(input logic [5:0] c);
        return (c >= 6'h28) ? 7'h50 : {c, 1'b0};
    endfunction : adb
    // unassigned codes leave the old setting in place
    task automatic apply(input logic [7:0] s, input logic [7:0] v);
        case (s)
            8'h40: if (v[1:0] != 2'h2) e_src = v[1:0];
            8'h41: {e_wide, e_loud} = v[1:0];
            8'h42: e_low = v[3:0];
            8'h43: e_high = v[3:0];
            8'h44: e_left = v[5:0];
            8'h45: e_right = v[5:0];
            8'h46: if (v[2]) e_mode = v[1] ? 2'h2 : {1'b0, v[0]};
            default: ;
        endcase
    endtask : apply

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                $time, seen, exp);
        end
    endtask : check
    task automatic check_all();
        check(64'({source_sel, mute_on, loudness_on, widening_on,
            low_tone_code, high_tone_code, low_tone_db, high_tone_db,
            left_atten_code, right_atten_code, left_atten_db,
            right_atten_db, matrix_mode}),
            64'({e_src, e_src == 2'h3, e_loud, e_wide, e_low, e_high,
            tdb(e_low), tdb(e_high), e_left, e_right, adb(e_left),
            adb(e_right), e_mode}));
    endtask : check_all

    // ========================================================
    // command port cycles
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    // one whole frame, then let the decoder land the setting
    task automatic send(input logic [7:0] s, input logic [7:0] v);
        logic [15:0] st;
        int n0;
        n0 = n_applied;
        wr(ACSD_REG_CMD, {s, v});
        st = 16'h0001;
        for (int i = 0; i < 400 && st[0] !== 1'b0; i++)
            rd(ACSD_REG_STATUS, st);
        check(64'(st[0]), 64'h0);
        repeat (8) @(posedge clk);
        check(64'(n_applied - n0), 64'(s[7:3] == 5'h08));
        apply(s, v);
        check_all();
    endtask : send

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // applied pulses, counted so each command can be held to one
    always @(posedge clk)
    begin
        if (cmd_applied === 1'b1)
            n_applied++;
    end

    // hang guard, generous over the roughly 6600 cycles needed
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    // ========================================================
    // main sequence
    initial
    begin
        void'($urandom(32'h444B2516));
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1 check_all();
        $display("test reset done");
        foreach (corners[i])
            send(corners[i][15:8], corners[i][7:0]);
        $display("test corners done");
        // selectors spread over both sides of the device's range
        repeat (24)
            send(8'h3E + 8'($urandom_range(11)), 8'($urandom));
        $display("test random done");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            flag_one_n <= i[0];
            flag_two_n <= i[1];
            // random value bits: the controller must leave the line free
            send(8'h47, 8'($urandom));
            rd(ACSD_REG_RXVAL, d);
            check(64'(d), 64'({8'h00, 6'h3F, i[1], i[0]}));
        end
        $display("test flags done");
        rd(4'h9, d);
        check(64'(d), 64'h0);
        $display("test unmapped done");
        wrap_up();
    end
endmodule : test_audio_control_serial_decoder
